//--- src/sigma_adc_sequencer.sv
// Sequencer, offset correction, window compare and mic path of the converter
`timescale 1ns/10ps
`default_nettype none
module sigma_adc_sequencer
   import adc_seq_pkg::*;
#(
   parameter int W = 16
) (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // Command bits, written with a one-cycle write strobe
   input wire logic cmd_we_in,
   input wire logic analog_power_on_in,
   input wire logic software_convert_start_in,
   input wire logic calibration_enable_in,
   input wire logic auto_offset_enable_in,
   input wire logic window_compare_enable_in,
   input wire logic mic_convert_on_in,
   input wire logic transfer_request_enable_in,
   input wire logic stop_in,
   input wire logic calibration_disable_strobe_in,
   input wire logic converter_reset_in,
   // Setup fields, written with a one-cycle write strobe
   input wire logic setup_we_in,
   input wire logic [2:0] input_channel_select_in,
   input wire logic continuous_select_in,
   input wire logic [1:0] oversampling_ratio_in,
   input wire logic [1:0] attenuation_select_in,
   input wire logic [1:0] bias_select_in,
   input wire logic filter_bypass_in,
   input wire logic mic_clock_enable_in,
   input wire logic mic_clock_divide_in,
   // Offset and limits
   input wire logic offset_we_in,
   input wire logic [31:0] offset_in,
   input wire logic limit_we_in,
   input wire logic [31:0] upper_limit_in,
   input wire logic [31:0] lower_limit_in,
   // Flag clear strobes
   input wire logic flag_clear_in,
   // Modulator bit stream and microphone pins
   input wire logic modulator_bit_in,
   input wire logic mic_data_in,
   // Analog side controls
   output logic [6:0] input_switch_out,
   output logic [1:0] attenuation_out,
   output logic [1:0] bias_out,
   output logic analog_enable_out,
   output logic mic_clock_out,
   // Status
   output logic busy_out,
   output logic [31:0] conversion_result_out,
   output logic [31:0] offset_out,
   output logic [15:0] full_scale_out,
   output logic calibration_done_flag_out,
   output logic conversion_done_flag_out,
   output logic window_hit_flag_out,
   output logic analog_power_on_out,
   output logic software_convert_start_out,
   output logic calibration_enable_out,
   output logic mic_convert_on_out,
   output logic transfer_request_enable_out,
   output logic window_compare_enable_out
);
   // ==========================================================
   // Command and setup registers
   logic auto_offset_r;
   logic [2:0] chan_r;
   logic continuous_select_r;
   logic [1:0] osr_r;
   logic bypass_r;
   logic mic_clk_en_r;
   logic mic_div_r;
   logic [31:0] upper_r;
   logic [31:0] lower_r;
   seq_state_t state_r;
   logic end_conv;
   logic [7:0] ratio;

   always_comb begin
      unique case (osr_r)
         2'h0: ratio = RATIO_0;
         2'h1: ratio = RATIO_1;
         2'h2: ratio = RATIO_2;
         2'h3: ratio = RATIO_3;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || (cmd_we_in && converter_reset_in)) begin
         analog_power_on_out <= 1'b0;
         software_convert_start_out <= 1'b0;
         auto_offset_r <= 1'b0;
         window_compare_enable_out <= 1'b0;
         mic_convert_on_out <= 1'b0;
         transfer_request_enable_out <= 1'b0;
      end else if (cmd_we_in && stop_in) begin
         analog_power_on_out <= 1'b0;
         software_convert_start_out <= 1'b0;
         mic_convert_on_out <= 1'b0;
         transfer_request_enable_out <= 1'b0;
      end else if (cmd_we_in) begin
         analog_power_on_out <= analog_power_on_in;
         software_convert_start_out <= software_convert_start_in;
         auto_offset_r <= auto_offset_enable_in;
         window_compare_enable_out <= window_compare_enable_in;
         mic_convert_on_out <= mic_convert_on_in;
         transfer_request_enable_out <= transfer_request_enable_in;
      end else if (end_conv && !continuous_select_r) begin
         software_convert_start_out <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || (cmd_we_in && converter_reset_in)) begin
         calibration_enable_out <= 1'b0;
      end else if (cmd_we_in && calibration_disable_strobe_in) begin
         calibration_enable_out <= 1'b0;
      end else if (cmd_we_in && calibration_enable_in) begin
         calibration_enable_out <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || (cmd_we_in && converter_reset_in)) begin
         chan_r <= CH_NONE;
         continuous_select_r <= 1'b0;
         osr_r <= 2'h0;
         attenuation_out <= 2'h0;
         bias_out <= 2'h0;
         bypass_r <= 1'b0;
         mic_clk_en_r <= 1'b0;
         mic_div_r <= 1'b0;
      end else if (setup_we_in && !busy_out) begin
         chan_r <= input_channel_select_in;
         continuous_select_r <= continuous_select_in;
         osr_r <= oversampling_ratio_in;
         attenuation_out <= attenuation_select_in;
         bias_out <= bias_select_in;
         bypass_r <= filter_bypass_in;
         mic_clk_en_r <= mic_clock_enable_in;
         mic_div_r <= mic_clock_divide_in;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || (cmd_we_in && converter_reset_in)) begin
         upper_r <= UPPER_RST;
      end else if (limit_we_in) begin
         upper_r <= upper_limit_in;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         lower_r <= ZERO32;
      end else if (limit_we_in) begin
         lower_r <= lower_limit_in;
      end
   end

   // ==========================================================
   // Input routing
   // channel to switches
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         input_switch_out <= 7'h00;
      end else begin
         input_switch_out <= 7'h00;
         unique case (chan_r)
            CH_SE_B: begin
               input_switch_out[SW_BIAS_P] <= 1'b1;
               input_switch_out[SW_B_N] <= 1'b1;
            end
            CH_SE_A: begin
               input_switch_out[SW_A_P] <= 1'b1;
               input_switch_out[SW_BIAS_N] <= 1'b1;
            end
            CH_DIFF: begin
               input_switch_out[SW_A_P] <= 1'b1;
               input_switch_out[SW_B_N] <= 1'b1;
            end
            CH_TEMP: input_switch_out[SW_TEMP] <= 1'b1;
            CH_BATT: input_switch_out[SW_BATT] <= 1'b1;
            CH_SHORT: input_switch_out[SW_MID] <= 1'b1;
            default: input_switch_out <= 7'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         full_scale_out <= FS_FILT_HIGH;
      end else if (osr_r[1]) begin
         full_scale_out <= bypass_r ? FS_BYP_LOW : FS_FILT_LOW;
      end else begin
         full_scale_out <= bypass_r ? FS_BYP_HIGH : FS_FILT_HIGH;
      end
   end

   // ==========================================================
   // Sampling enables and pin synchronisers
   logic [6:0] mod_cnt_r;
   logic mod_tick_r;
   logic [2:0] mic_sync_r;
   logic [5:0] mic_cnt_r;
   logic mic_rise_r;
   logic mic_run;
   logic [5:0] mic_half;

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || mod_cnt_r == 7'(MOD_DIV - 1)) begin
         mod_cnt_r <= 7'h00;
      end else begin
         mod_cnt_r <= mod_cnt_r + 7'h01;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         mod_tick_r <= 1'b0;
      end else begin
         mod_tick_r <= mod_cnt_r == 7'(MOD_DIV - 1);
      end
   end

   // Three stages; value used once stages two and three agree
   logic mic_bit_r;
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         mic_sync_r <= 3'h0;
         mic_bit_r <= 1'b0;
      end else begin
         mic_sync_r <= {mic_sync_r[1:0], mic_data_in};
         if (mic_sync_r[1] == mic_sync_r[2]) begin
            mic_bit_r <= mic_sync_r[2];
         end
      end
   end

   assign mic_run = mic_clk_en_r;
   assign mic_half = mic_div_r ? 6'(MIC_HALF_SLOW) : 6'(MIC_HALF_FAST);
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || !mic_run) begin
         mic_cnt_r <= 6'h00;
         mic_clock_out <= 1'b0;
         mic_rise_r <= 1'b0;
      end else if (mic_cnt_r >= mic_half - 6'h01) begin
         mic_cnt_r <= 6'h00;
         mic_clock_out <= !mic_clock_out;
         // Sample data at falling edge, mic drives it after rise
         mic_rise_r <= mic_clock_out;
      end else begin
         mic_cnt_r <= mic_cnt_r + 6'h01;
         mic_rise_r <= 1'b0;
      end
   end

   // ==========================================================
   // Phase sequencer
   logic [10:0] wake_cnt_r;
   logic [5:0] cal_cnt_r;
   logic filt_clear;
   logic filt_en;
   logic filt_bit;
   logic [W-1:0] filt_sum;
   logic filt_done;
   logic mic_mode;

   assign mic_mode = mic_convert_on_out;
   // Held clear through wake so acquisition spans a full ratio
   assign filt_clear = (state_r == ST_IDLE || state_r == ST_WAKE) && !mic_mode;
   assign filt_en = mic_mode ? mic_rise_r : mod_tick_r;
   assign filt_bit = mic_mode ? mic_bit_r : modulator_bit_in;

   adc_decim #(.W(W)) u_decim (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .clear_in(filt_clear),
      .sample_en_in(filt_en),
      .sample_in(filt_bit),
      .ratio_in(ratio),
      .sum_out(filt_sum),
      .done_out(filt_done)
   );

   assign end_conv = (state_r == ST_ELAB);

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || (cmd_we_in && (stop_in || converter_reset_in))) begin
         state_r <= ST_IDLE;
         wake_cnt_r <= 11'h000;
         cal_cnt_r <= 6'h00;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               wake_cnt_r <= 11'h000;
               if (analog_power_on_out && software_convert_start_out && !mic_mode) begin
                  state_r <= ST_WAKE;
               end
            end
            ST_WAKE: begin
               wake_cnt_r <= wake_cnt_r + 11'h001;
               if (wake_cnt_r == 11'(WAKE_CYCLES - 1)) begin
                  cal_cnt_r <= 6'h00;
                  state_r <= (calibration_enable_out && auto_offset_r) ? ST_CAL : ST_ACQ;
               end
            end
            ST_CAL: begin
               if (filt_done) begin
                  cal_cnt_r <= cal_cnt_r + 6'h01;
                  if (cal_cnt_r == 6'(CAL_SAMPLES - 1)) begin
                     state_r <= ST_ACQ;
                  end
               end
            end
            ST_ACQ: begin
               if (filt_done) begin
                  state_r <= ST_ELAB;
               end
            end
            ST_ELAB: begin
               state_r <= (continuous_select_r && software_convert_start_out) ? ST_ACQ : ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         busy_out <= 1'b0;
         analog_enable_out <= 1'b0;
      end else begin
         busy_out <= (state_r != ST_IDLE) && !(state_r == ST_ELAB && !continuous_select_r);
         analog_enable_out <= analog_power_on_out;
      end
   end

   // ==========================================================
   // Offset, result and flags
   logic [W-1:0] corrected;
   logic [W-1:0] offset_sel;
   logic window_hit;
   assign offset_sel = bypass_r ? offset_out[15:0] : offset_out[31:16];
   assign corrected = filt_sum - offset_sel;
   assign window_hit = (32'(corrected) <= upper_r) && (32'(corrected) >= lower_r);

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         offset_out <= ZERO32;
      end else if (state_r == ST_CAL && filt_done && cal_cnt_r == 6'(CAL_SAMPLES - 1)) begin
         if (bypass_r) begin
            offset_out[15:0] <= filt_sum;
         end else begin
            offset_out[31:16] <= filt_sum;
         end
      end else if (offset_we_in) begin
         offset_out <= offset_in;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || (cmd_we_in && converter_reset_in)) begin
         conversion_result_out <= ZERO32;
      end else if ((state_r == ST_ACQ || mic_mode) && filt_done) begin
         conversion_result_out <= bypass_r ? {16'h0000, corrected} : {corrected, 16'h0000};
      end
   end

   // Set wins over a same-cycle clear
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         calibration_done_flag_out <= 1'b0;
         conversion_done_flag_out <= 1'b0;
         window_hit_flag_out <= 1'b0;
      end else begin
         if (state_r == ST_CAL && filt_done && cal_cnt_r == 6'(CAL_SAMPLES - 1)) begin
            calibration_done_flag_out <= 1'b1;
         end else if (flag_clear_in) begin
            calibration_done_flag_out <= 1'b0;
         end
         if ((state_r == ST_ACQ || mic_mode) && filt_done) begin
            conversion_done_flag_out <= 1'b1;
         end else if (flag_clear_in) begin
            conversion_done_flag_out <= 1'b0;
         end
         if ((state_r == ST_ACQ || mic_mode) && filt_done && window_compare_enable_out
             && window_hit) begin
            window_hit_flag_out <= 1'b1;
         end else if (flag_clear_in) begin
            window_hit_flag_out <= 1'b0;
         end
      end
   end
endmodule : sigma_adc_sequencer
`default_nettype wire

//--- src/adc_seq_pkg.sv
// Constants for the oversampling converter sequencer
package adc_seq_pkg;
   // ==========================================================
   // Clock and timing
   localparam int CLK_MHZ = 100;
   localparam int WAKE_NS = 6000;
   localparam int WAKE_CYCLES = (WAKE_NS * CLK_MHZ + 999) / 1000;
   localparam int MOD_RATE_KHZ = 1000;
   localparam int MOD_DIV = CLK_MHZ * 1000 / MOD_RATE_KHZ;
   localparam int CAL_SAMPLES = 32;
   // Mic clock half periods: 1.6 MHz and 0.8 MHz from 100 MHz
   localparam int MIC_FAST_KHZ = 1600;
   localparam int MIC_SLOW_KHZ = 800;
   localparam int MIC_HALF_FAST = CLK_MHZ * 1000 / (2 * MIC_FAST_KHZ);
   localparam int MIC_HALF_SLOW = CLK_MHZ * 1000 / (2 * MIC_SLOW_KHZ);
   // ==========================================================
   // Oversampling ratios per code 0..3
   localparam logic [7:0] RATIO_0 = 8'hC8;
   localparam logic [7:0] RATIO_1 = 8'h64;
   localparam logic [7:0] RATIO_2 = 8'h40;
   localparam logic [7:0] RATIO_3 = 8'h20;
   // Full-scale codes, filter in use / bypassed
   localparam logic [15:0] FS_FILT_LOW = 16'h4144;
   localparam logic [15:0] FS_FILT_HIGH = 16'h4BFA;
   localparam logic [15:0] FS_BYP_LOW = 16'h8000;
   localparam logic [15:0] FS_BYP_HIGH = 16'h9503;
   // ==========================================================
   // Channel codes
   localparam logic [2:0] CH_NONE = 3'h0;
   localparam logic [2:0] CH_SE_B = 3'h1;
   localparam logic [2:0] CH_SE_A = 3'h2;
   localparam logic [2:0] CH_DIFF = 3'h3;
   localparam logic [2:0] CH_TEMP = 3'h4;
   localparam logic [2:0] CH_BATT = 3'h5;
   localparam logic [2:0] CH_SHORT = 3'h6;
   // Switch bits of the input route
   localparam int SW_A_P = 0;
   localparam int SW_B_N = 1;
   localparam int SW_BIAS_P = 2;
   localparam int SW_BIAS_N = 3;
   localparam int SW_TEMP = 4;
   localparam int SW_BATT = 5;
   localparam int SW_MID = 6;
   // Reset values
   localparam logic [31:0] UPPER_RST = 32'hFFFFFFFF;
   localparam logic [31:0] ZERO32 = 32'h00000000;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAKE = 3'b001,
      ST_CAL = 3'b010,
      ST_ACQ = 3'b011,
      ST_ELAB = 3'b100
   } seq_state_t;
endpackage : adc_seq_pkg

//--- src/adc_decim.sv
// Sum-of-samples decimator over a programmable number of inputs
`timescale 1ns/10ps
`default_nettype none
module adc_decim #(
   parameter int W = 16
) (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic clear_in,
   input wire logic sample_en_in,
   input wire logic sample_in,
   input wire logic [7:0] ratio_in,
   output logic [W-1:0] sum_out,
   output logic done_out
);
   logic [7:0] cnt_r;
   logic [W-1:0] acc_r;
   // ==========================================================
   // Accumulate bipolar samples, dump every ratio inputs
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || clear_in) begin
         cnt_r <= 8'h00;
         acc_r <= '0;
         sum_out <= '0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (sample_en_in) begin
            if (cnt_r == ratio_in - 8'h01) begin
               sum_out <= sample_in ? acc_r + W'(1) : acc_r - W'(1);
               done_out <= 1'b1;
               acc_r <= '0;
               cnt_r <= 8'h00;
            end else begin
               acc_r <= sample_in ? acc_r + W'(1) : acc_r - W'(1);
               cnt_r <= cnt_r + 8'h01;
            end
         end
      end
   end
endmodule : adc_decim
`default_nettype wire

//--- testbench/mic_model.sv
// Far-side model: modulator bit source and microphone stream
`timescale 1ns/10ps
`default_nettype none
module mic_model (
   input wire logic mic_clock_in,
   output logic mic_data_out,
   output logic modulator_bit_out
);
   // ==========================
   // Stream
   initial mic_data_out = 1'h0;
   always @(posedge mic_clock_in) begin
      mic_data_out <= ~mic_data_out;
   end
   // Constant bit keeps the expected sum exact
   assign modulator_bit_out = 1'h1;
endmodule : mic_model
`default_nettype wire

//--- testbench/adc_seq_assertions.sv
// Port checker for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module adc_seq_checker
   import adc_seq_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic cmd_we_in,
   input wire logic analog_power_on_in,
   input wire logic software_convert_start_in,
   input wire logic calibration_enable_in,
   input wire logic mic_convert_on_in,
   input wire logic stop_in,
   input wire logic calibration_disable_strobe_in,
   input wire logic converter_reset_in,
   input wire logic setup_we_in,
   input wire logic [1:0] oversampling_ratio_in,
   input wire logic filter_bypass_in,
   input wire logic flag_clear_in,
   input wire logic [1:0] attenuation_out,
   input wire logic [1:0] bias_out,
   input wire logic busy_out,
   input wire logic [31:0] conversion_result_out,
   input wire logic [15:0] full_scale_out,
   input wire logic conversion_done_flag_out,
   input wire logic window_hit_flag_out,
   input wire logic analog_power_on_out,
   input wire logic software_convert_start_out,
   input wire logic calibration_enable_out,
   input wire logic mic_convert_on_out,
   input wire logic transfer_request_enable_out,
   input wire logic window_compare_enable_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   wire logic rst_cmd = cmd_we_in && converter_reset_in;
   logic [15:0] fs_exp_r;
   // ==========================
   // Expected full scale
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || rst_cmd) begin
         fs_exp_r <= FS_FILT_HIGH;
      end else if (setup_we_in && !busy_out) begin
         fs_exp_r <= oversampling_ratio_in[1] ? (filter_bypass_in ? FS_BYP_LOW : FS_FILT_LOW)
            : (filter_bypass_in ? FS_BYP_HIGH : FS_FILT_HIGH);
      end
   end
   sequence start_s;
      cmd_we_in && analog_power_on_in && software_convert_start_in && !mic_convert_on_in
         && !stop_in && !converter_reset_in && !busy_out;
   endsequence
   sequence busy_rise_s;
      !busy_out ##1 busy_out;
   endsequence
   // ==========================
   // Assertions
   busy_start_a: assert property (start_s |-> ##2 busy_rise_s)
      else $error("busy late");
   setup_lock_a: assert property (busy_out && setup_we_in && !rst_cmd
      |=> $stable(attenuation_out) && $stable(bias_out))
      else $error("setup taken while busy");
   stop_clear_a: assert property (cmd_we_in && stop_in |=> !(analog_power_on_out
      || software_convert_start_out || mic_convert_on_out || transfer_request_enable_out))
      else $error("stop left enables");
   cal_hold_a: assert property (calibration_enable_out
      && !(cmd_we_in && (calibration_disable_strobe_in || converter_reset_in))
      |=> calibration_enable_out) else $error("cal enable lost");
   cal_clear_a: assert property (cmd_we_in && calibration_disable_strobe_in
      && !calibration_enable_in |=> !calibration_enable_out) else $error("cal enable kept");
   conv_reset_a: assert property (rst_cmd
      |=> conversion_result_out == ZERO32 && !analog_power_on_out) else $error("reset kept");
   full_scale_a: assert property (setup_we_in && !busy_out && !rst_cmd
      |-> ##[1:2] full_scale_out == fs_exp_r) else $error("full scale wrong");
   window_en_a: assert property ($rose(window_hit_flag_out)
      |-> window_compare_enable_out) else $error("hit without enable");
   done_hold_a: assert property (conversion_done_flag_out && !flag_clear_in
      |=> conversion_done_flag_out) else $error("done flag dropped");
   flag_clear_a: assert property (flag_clear_in && !busy_out && !mic_convert_on_out
      && !software_convert_start_out |=> !conversion_done_flag_out && !window_hit_flag_out)
      else $error("flags not cleared");
endmodule : adc_seq_checker
bind sigma_adc_sequencer adc_seq_checker i_adc_seq_checker (.*);
`default_nettype wire

//--- testbench/sigma_adc_sequencer_test.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module sigma_adc_sequencer_test
   import adc_seq_pkg::*;
();
   logic core_clk_in, rstn_in, cmd_we_in, setup_we_in, offset_we_in, limit_we_in, flag_clear_in;
   logic analog_power_on_in, software_convert_start_in, calibration_enable_in, stop_in;
   logic auto_offset_enable_in, window_compare_enable_in, mic_convert_on_in;
   logic transfer_request_enable_in, calibration_disable_strobe_in, converter_reset_in;
   logic continuous_select_in, filter_bypass_in, mic_clock_enable_in, mic_clock_divide_in;
   logic modulator_bit_in, mic_data_in, analog_enable_out, mic_clock_out, busy_out;
   logic [2:0] input_channel_select_in;
   logic [1:0] oversampling_ratio_in, attenuation_select_in, bias_select_in;
   logic [31:0] offset_in, upper_limit_in, lower_limit_in, conversion_result_out, offset_out;
   logic [6:0] input_switch_out;
   logic [1:0] attenuation_out, bias_out;
   logic calibration_done_flag_out, conversion_done_flag_out, window_hit_flag_out;
   logic analog_power_on_out, software_convert_start_out, calibration_enable_out;
   logic mic_convert_on_out, transfer_request_enable_out, window_compare_enable_out;
   logic [15:0] full_scale_out;
   logic [6:0] sw_exp [8] = '{7'h00, 7'h06, 7'h09, 7'h03, 7'h10, 7'h20, 7'h40, 7'h00};
   logic [6:0] sw_msk [8] = '{7'h7F, 7'h7F, 7'h7F, 7'h7F, 7'h10, 7'h20, 7'h40, 7'h00};
   int miscompares = 0;
   int checked = 0;
   int n;
   sigma_adc_sequencer i_sigma_adc_sequencer (.*);
   mic_model i_mic_model (.mic_clock_in(mic_clock_out), .mic_data_out(mic_data_in),
      .modulator_bit_out(modulator_bit_in));
   // ==========================
   // Tasks
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [4:0] we);
      @(posedge core_clk_in);
      {cmd_we_in, setup_we_in, offset_we_in, limit_we_in, flag_clear_in} <= we;
      @(posedge core_clk_in);
      {cmd_we_in, setup_we_in, offset_we_in, limit_we_in, flag_clear_in} <= 5'h00;
   endtask : wr
   task automatic cmd(input logic [9:0] v);
      {analog_power_on_in, software_convert_start_in, calibration_enable_in,
         auto_offset_enable_in, window_compare_enable_in, mic_convert_on_in,
         transfer_request_enable_in, stop_in, calibration_disable_strobe_in,
         converter_reset_in} <= v;
      wr(5'h10);
   endtask : cmd
   task automatic setup(input logic [10:0] v);
      {input_channel_select_in, continuous_select_in, oversampling_ratio_in,
         attenuation_select_in, filter_bypass_in, mic_clock_enable_in, mic_clock_divide_in} <= v;
      bias_select_in <= 2'h2;
      wr(5'h08);
      repeat (2) @(posedge core_clk_in);
      #1;
   endtask : setup
   task automatic conv(input logic [9:0] v, output int c);
      time t;
      cmd(v);
      t = $time;
      repeat (2) @(posedge core_clk_in);
      #1;
      chk("busy", 32'(busy_out), 32'h1);
      // Refused write must not move the attenuation
      attenuation_select_in <= 2'h2;
      wr(5'h09);
      #1;
      chk("attenuation", 32'(attenuation_out), 32'h0);
      @(posedge conversion_done_flag_out);
      c = int'(($time - t) / 10);
      @(posedge core_clk_in);
      #1;
   endtask : conv
   task automatic ival(output int p);
      time t;
      wr(5'h01);
      @(posedge conversion_done_flag_out);
      t = $time;
      wr(5'h01);
      @(posedge conversion_done_flag_out);
      p = int'(($time - t) / 10);
   endtask : ival
   task automatic period(output int p);
      time t;
      @(posedge mic_clock_out);
      t = $time;
      @(posedge mic_clock_out);
      p = int'(($time - t) / 10);
   endtask : period
   task automatic finish_test();
      if (miscompares == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test
   // ==========================
   // Clock, watchdog, tests
   initial begin
      core_clk_in = 1'h0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   initial begin
      repeat (60000) @(posedge core_clk_in);
      miscompares++;
      finish_test();
   end
   initial begin
      rstn_in <= 1'h0;
      {cmd_we_in, setup_we_in, offset_we_in, limit_we_in, flag_clear_in} <= 5'h00;
      {offset_in, upper_limit_in, lower_limit_in} <= '0;
      cmd(10'h000);
      rstn_in <= 1'h1;
      setup(11'h000);
      @(posedge core_clk_in);
      #1;
      chk("full_scale", 32'(full_scale_out), 32'(FS_FILT_HIGH));
      for (int k = 0; k < 8; k++) begin
         setup({k[2:0], 1'h0, k[1:0], 2'h0, k[2], 2'h0});
         chk("switches", 32'(input_switch_out & sw_msk[k]), 32'(sw_exp[k]));
         chk("full_scale", 32'(full_scale_out), 32'(k[1] ? (k[2] ? FS_BYP_LOW : FS_FILT_LOW)
            : (k[2] ? FS_BYP_HIGH : FS_FILT_HIGH)));
      end
      setup({3'h3, 1'h0, 2'h3, 2'h0, 1'h0, 2'h0});
      offset_in <= 32'h00050000;
      upper_limit_in <= 32'hFFFFFFFF;
      wr(5'h06);
      conv(10'h320, n);
      chk("wake_time", 32'(n > WAKE_CYCLES + 31 * MOD_DIV && n < WAKE_CYCLES + 34 * MOD_DIV), 32'h1);
      chk("result", 32'(conversion_result_out[31:16]), 32'h0000001B);
      chk("hit", 32'(window_hit_flag_out), 32'h1);
      chk("cal_done", 32'(calibration_done_flag_out), 32'h0);
      chk("start", 32'(software_convert_start_out | busy_out), 32'h0);
      setup({3'h3, 1'h0, 2'h3, 2'h0, 1'h1, 2'h0});
      offset_in <= 32'h00000003;
      {upper_limit_in, lower_limit_in} <= {32'h000000C8, 32'h00000064};
      wr(5'h07);
      conv(10'h320, n);
      chk("result", 32'(conversion_result_out[15:0]), 32'h0000001D);
      chk("hit", 32'(window_hit_flag_out), 32'h0);
      setup({3'h3, 1'h1, 2'h3, 2'h0, 1'h0, 2'h0});
      conv(10'h308, n);
      ival(n);
      chk("interval", 32'(n > 32 * MOD_DIV - 6 && n < 32 * MOD_DIV + 6), 32'h1);
      cmd(10'h004);
      repeat (3) @(posedge core_clk_in);
      #1;
      chk("stopped", 32'(busy_out | transfer_request_enable_out | analog_power_on_out), 32'h0);
      cmd(10'h080);
      cmd(10'h000);
      #1;
      chk("cal_en", 32'(calibration_enable_out), 32'h1);
      cmd(10'h002);
      #1;
      chk("cal_en", 32'(calibration_enable_out), 32'h0);
      cmd(10'h001);
      @(posedge core_clk_in);
      #1;
      chk("full_scale", 32'(full_scale_out), 32'(FS_FILT_HIGH));
      chk("result", conversion_result_out, ZERO32);
      chk("offset", offset_out, 32'h00000003);
      for (int d = 0; d < 2; d++) begin
         setup({3'h0, 1'h0, 2'h3, 2'h0, 1'h0, 1'h1, d[0]});
         cmd(10'h010);
         period(n);
         chk("mic_period", 32'(n), 32'(d ? 2 * MIC_HALF_SLOW : 2 * MIC_HALF_FAST));
         ival(n);
         chk("mic_rate", 32'(n > 64 * (d ? MIC_HALF_SLOW : MIC_HALF_FAST) - 6
            && n < 64 * (d ? MIC_HALF_SLOW : MIC_HALF_FAST) + 6), 32'h1);
         cmd(10'h004);
         #1;
         chk("mic_convert_on", 32'(mic_convert_on_out), 32'h0);
      end
      finish_test();
   end
endmodule : sigma_adc_sequencer_test
`default_nettype wire
